// File: design/hsa_pkg.sv
// Package of constants and types for the two-wire slave and alert interface.
package hsa_pkg;

    localparam int HSA_NUM_ALERT = 52;
    localparam logic [6:0] HSA_ADDR_BASE = 7'h10;
    localparam logic [6:0] HSA_ADDR_MASS = 7'h1F;
    localparam logic [6:0] HSA_ADDR_ARA = 7'h0C;
    localparam logic [7:0] HSA_BYTE_FILL = 8'hFF;
    localparam logic [7:0] HSA_RAM_FIRST = 8'h41;
    localparam logic [7:0] HSA_RAM_LAST = 8'h79;
    localparam logic [1:0] HSA_SEL_LOW = 2'h0;
    localparam logic [1:0] HSA_SEL_OPEN = 2'h1;
    localparam logic [1:0] HSA_SEL_HIGH = 2'h2;
    localparam int HSA_CLK_MHZ = 100;
    localparam int HSA_STUCK_MS = 30;
    localparam int HSA_STUCK_CYC = HSA_STUCK_MS * 1000 * HSA_CLK_MHZ;
    localparam logic [1:0] HSA_PAGE_LIMIT = 2'h2;

    typedef enum logic [2:0] {
        HSA_IDLE = 3'b000,
        HSA_ADDR = 3'b001,
        HSA_WRITE = 3'b010,
        HSA_READ = 3'b011,
        HSA_ARA = 3'b100
    } hsa_state_e;

    // Register access request toward the internal register space.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic lsb;
        logic [7:0] data;
    } hsa_req_s;

endpackage

// File: design/hsa_slave.sv
// Two-wire slave with register addressing, alert response and stuck-bus reset.
`timescale 1ns/1ps
`default_nettype none
module hsa_slave
    import hsa_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Bus pins.
    input wire logic i_scl,
    input wire logic i_serial_data_input,
    output logic o_serial_data_output_oe,
    output logic o_alert_n_oe,
    // Address select straps, encoded low, open, high.
    input wire logic [1:0] i_addr_select_high,
    input wire logic [1:0] i_addr_select_low,
    // Control bits.
    input wire logic i_mass_write_en,
    input wire logic i_page_en,
    input wire logic i_conv_done_alert_en,
    input wire logic i_conv_done,
    // Alert terms, each a fault or event bit and its enable.
    input wire logic [HSA_NUM_ALERT-1:0] i_alert_bits,
    input wire logic [HSA_NUM_ALERT-1:0] i_alert_en,
    // Software write to the pending flag.
    input wire logic i_flag_wr,
    input wire logic i_flag_wdata,
    // Register space.
    output hsa_req_s o_req,
    input wire logic [7:0] i_rdata,
    // Status.
    output logic o_alert_pending_flag,
    output logic o_broadcast_mode,
    output logic o_busy
);
    logic scl;
    logic sda;
    logic scl_d;
    logic sda_d;
    hsa_state_e state;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic [7:0] reg_addr;
    logic lsb;
    logic [1:0] count;
    logic cmd_seen;
    logic ack_phase;
    logic drive;
    logic [7:0] tx;
    logic master_nack;
    logic [31:0] stuck;
    logic [HSA_NUM_ALERT-1:0] terms_d;
    logic conv_d;

    // ****************************************
    // Input conditioning
    // ****************************************
    hsa_sync u_sync_scl (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_scl), .o_level(scl));
    hsa_sync u_sync_sda (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_serial_data_input), .o_level(sda));

    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_det = scl & scl_d & sda_d & ~sda;
    wire stop_det = scl & scl_d & ~sda_d & sda;

    // ****************************************
    // Address decode
    // ****************************************
    wire bcast = (i_addr_select_high == HSA_SEL_HIGH) && (i_addr_select_low == HSA_SEL_LOW);
    wire [2:0] sel_code =
        (i_addr_select_high == HSA_SEL_LOW && i_addr_select_low == HSA_SEL_LOW) ? 3'h0 :
        (i_addr_select_high == HSA_SEL_LOW && i_addr_select_low == HSA_SEL_OPEN) ? 3'h1 :
        (i_addr_select_high == HSA_SEL_HIGH && i_addr_select_low == HSA_SEL_OPEN) ? 3'h2 :
        (i_addr_select_high == HSA_SEL_LOW && i_addr_select_low == HSA_SEL_HIGH) ? 3'h3 :
        (i_addr_select_high == HSA_SEL_OPEN && i_addr_select_low == HSA_SEL_LOW) ? 3'h4 :
        (i_addr_select_high == HSA_SEL_HIGH && i_addr_select_low == HSA_SEL_HIGH) ? 3'h6 :
        (i_addr_select_high == HSA_SEL_OPEN && i_addr_select_low == HSA_SEL_HIGH) ? 3'h7 : 3'h5;
    wire [6:0] own_addr = HSA_ADDR_BASE | {4'h0, sel_code};
    wire [6:0] rx_addr = shreg[7:1];
    wire rx_read = shreg[0];
    wire hit_own = (rx_addr == own_addr);
    wire hit_mass = i_mass_write_en && (rx_addr == HSA_ADDR_MASS) && !rx_read;
    wire hit_ara = o_alert_pending_flag && (rx_addr == HSA_ADDR_ARA) && rx_read;
    wire is_ram = (reg_addr >= HSA_RAM_FIRST) && (reg_addr <= HSA_RAM_LAST);
    wire over = !i_page_en && (count == HSA_PAGE_LIMIT);
    wire [7:0] rd_byte = over ? HSA_BYTE_FILL : i_rdata;
    wire stuck_clr = scl && !o_serial_data_output_oe;
    wire timeout = (stuck >= HSA_STUCK_CYC - 1);
    wire byte_done = scl_fall && !ack_phase && (bitcnt == 4'h8);
    wire [7:0] byte_in = {shreg[6:0], sda};
    wire [HSA_NUM_ALERT-1:0] terms = i_alert_bits & i_alert_en;
    wire term_rise = |(terms & ~terms_d);
    wire conv_rise = i_conv_done_alert_en && i_conv_done && !conv_d;
    wire [6:0] ara_addr = own_addr;

    // ****************************************
    // Protocol engine
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= HSA_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            reg_addr <= 8'h00;
            lsb <= 1'b0;
            count <= 2'h0;
            cmd_seen <= 1'b0;
            ack_phase <= 1'b0;
            drive <= 1'b0;
            tx <= 8'h00;
            master_nack <= 1'b0;
            o_serial_data_output_oe <= 1'b0;
            o_req <= '0;
            stuck <= 32'h0;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            o_req.wr <= 1'b0;
            o_req.rd <= 1'b0;
            // The address output follows the pointer, so read data is settled when a byte loads.
            o_req.addr <= reg_addr;
            o_req.lsb <= lsb;
            stuck <= stuck_clr ? 32'h0 : stuck + 32'h1;
            if (bcast || timeout) begin
                state <= HSA_IDLE;
                o_serial_data_output_oe <= 1'b0;
                drive <= 1'b0;
                ack_phase <= 1'b0;
                stuck <= 32'h0;
            end else if (start_det) begin
                state <= HSA_ADDR;
                bitcnt <= 4'h0;
                ack_phase <= 1'b0;
                drive <= 1'b0;
                o_serial_data_output_oe <= 1'b0;
            end else if (stop_det) begin
                state <= HSA_IDLE;
                drive <= 1'b0;
                o_serial_data_output_oe <= 1'b0;
            end else if (state != HSA_IDLE) begin
                if (scl_rise && !ack_phase) begin
                    shreg <= byte_in;
                    bitcnt <= bitcnt + 4'h1;
                    if ((state == HSA_ARA) && o_serial_data_output_oe == 1'b0 && tx[7] == 1'b0) begin
                        state <= HSA_IDLE;
                    end
                    // Lost arbitration: bus high while we sent a one is fine; we released and saw low.
                    if (state == HSA_ARA && tx[7] && !sda) begin
                        state <= HSA_IDLE;
                    end
                end
                if (scl_rise && ack_phase && drive) begin
                    master_nack <= sda;
                end
                if (byte_done) begin
                    ack_phase <= 1'b1;
                    bitcnt <= 4'h0;
                    o_serial_data_output_oe <= 1'b0;
                    case (state)
                        HSA_ADDR: begin
                            drive <= 1'b0;
                            if (hit_ara) begin
                                state <= HSA_ARA;
                                o_serial_data_output_oe <= 1'b1;
                            end else if (hit_own || hit_mass) begin
                                o_serial_data_output_oe <= 1'b1;
                                state <= rx_read ? HSA_READ : HSA_WRITE;
                                count <= 2'h0;
                                lsb <= 1'b0;
                                if (!rx_read) begin
                                    cmd_seen <= 1'b0;
                                end
                            end else begin
                                state <= HSA_IDLE;
                            end
                        end
                        HSA_WRITE: begin
                            drive <= 1'b0;
                            if (!cmd_seen) begin
                                reg_addr <= shreg;
                                cmd_seen <= 1'b1;
                                o_serial_data_output_oe <= 1'b1;
                            end else if (over) begin
                                state <= HSA_IDLE;
                            end else begin
                                o_serial_data_output_oe <= 1'b1;
                                o_req <= '{wr: 1'b1, rd: 1'b0, addr: reg_addr, lsb: lsb, data: shreg};
                                count <= count + 2'h1;
                                if (!is_ram || lsb) begin
                                    reg_addr <= reg_addr + 8'h01;
                                end
                                lsb <= is_ram && !lsb;
                            end
                        end
                        default: begin
                            drive <= 1'b1;
                        end
                    endcase
                end else if (scl_fall && ack_phase) begin
                    ack_phase <= 1'b0;
                    o_serial_data_output_oe <= 1'b0;
                    if (state == HSA_READ && !(drive && master_nack)) begin
                        // Load next read byte, MSB out on this low phase.
                        tx <= rd_byte;
                        o_serial_data_output_oe <= ~rd_byte[7];
                        o_req <= '{wr: 1'b0, rd: 1'b1, addr: reg_addr, lsb: lsb, data: 8'h00};
                        if (!over) begin
                            count <= count + 2'h1;
                            if (!is_ram || lsb) begin
                                reg_addr <= reg_addr + 8'h01;
                            end
                            lsb <= is_ram && !lsb;
                        end
                        drive <= 1'b1;
                    end else if (state == HSA_ARA && !drive) begin
                        tx <= {ara_addr, 1'b0};
                        o_serial_data_output_oe <= ~ara_addr[6];
                        drive <= 1'b1;
                    end else if (drive) begin
                        state <= HSA_IDLE;
                        drive <= 1'b0;
                    end
                end else if (scl_fall && !ack_phase) begin
                    if (drive) begin
                        tx <= {tx[6:0], 1'b1};
                        o_serial_data_output_oe <= ~tx[6];
                    end
                end
            end
        end
    end

    // ****************************************
    // Alert generation
    // ****************************************
    wire ara_won = (state == HSA_ARA) && drive && byte_done;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            terms_d <= '0;
            conv_d <= 1'b0;
            o_alert_pending_flag <= 1'b0;
            o_alert_n_oe <= 1'b0;
            o_broadcast_mode <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            terms_d <= terms;
            conv_d <= i_conv_done;
            o_broadcast_mode <= bcast;
            o_busy <= (state != HSA_IDLE);
            if (term_rise || conv_rise || (i_flag_wr && i_flag_wdata)) begin
                o_alert_pending_flag <= 1'b1;
            end else if (ara_won || (i_flag_wr && !i_flag_wdata)) begin
                o_alert_pending_flag <= 1'b0;
            end
            o_alert_n_oe <= o_alert_pending_flag;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // The clock line is only an input here.
    stuck_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
        timeout |=> !o_serial_data_output_oe && state == HSA_IDLE) else $error("stuck bus not released");
    timer_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        stuck_clr && !timeout |=> stuck == 32'h0) else $error("stuck timer not cleared");
    term_sets_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
        term_rise |=> o_alert_pending_flag) else $error("alert term lost");
    alert_follows_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_alert_pending_flag |=> o_alert_n_oe) else $error("alert pin not driven");
    bcast_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
        bcast |=> state == HSA_IDLE && !o_serial_data_output_oe) else $error("slave active in broadcast");
    start_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
        start_det && !bcast && !timeout |=> state == HSA_ADDR && bitcnt == 4'h0) else $error("start missed");
    stop_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
        stop_det && !start_det && !bcast |=> state == HSA_IDLE) else $error("stop missed");
    sw_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_flag_wr && i_flag_wdata |=> o_alert_pending_flag) else $error("flag write lost");
    conv_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        conv_rise |=> o_alert_pending_flag) else $error("conversion alert lost");
endmodule // hsa_slave
`default_nettype wire

// File: design/hsa_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
`timescale 1ns/1ps
`default_nettype none
module hsa_sync (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Pin and filtered level.
    input wire logic i_pin,
    output logic o_level
);
    logic s1;
    logic s2;
    logic s3;

    // A change is taken once the second and third stages agree.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            o_level <= 1'b1;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule // hsa_sync
`default_nettype wire

// File: test/hsa_bus_master.sv
// Behavioural bus master that drives the two-wire clock and data pins.
`timescale 1ns/1ps
`default_nettype none
module hsa_bus_master (
    // Level seen on the shared data line.
    input wire logic i_sda_wire,
    // Master drive, high means released.
    output logic o_scl,
    output logic o_sda
);
    // ************************************************************
    // Bus cycles: 125 ns per bit, data set 25 ns after clock falls.
    // ************************************************************
    localparam realtime T_SET = 25.0;
    localparam realtime T_HALF = 50.0;

    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // The long low phase lets a slave release its drive before the clock rises.
    task automatic start();
        #T_SET;
        o_sda = 1'b1;
        #T_HALF;
        o_scl = 1'b1;
        #T_SET;
        o_sda = 1'b0;
        #T_SET;
        o_scl = 1'b0;
    endtask

    task automatic stop();
        #T_SET;
        o_sda = 1'b0;
        #T_HALF;
        o_scl = 1'b1;
        #T_SET;
        o_sda = 1'b1;
        #T_SET;
    endtask

    task automatic xfer_bit(input logic b, output logic s);
        #T_SET;
        o_sda = b;
        #T_HALF;
        o_scl = 1'b1;
        #T_HALF;
        s = i_sda_wire;
        o_scl = 1'b0;
    endtask

    // Eight bits MSB first, then one handshake bit from the receiver.
    task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(tx[i], rx[i]);
        end
        xfer_bit(ack_in, ack_out);
    endtask
endmodule  // hsa_bus_master
`default_nettype wire

// File: test/test_i2c_slave_alert_interface.sv
// Self-checking bench for the two-wire slave and alert interface.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_alert_interface
    import hsa_pkg::*;
;
    // ************************************************************
    // Stimulus, register space model and checks.
    // ************************************************************
    localparam logic [31:0] STRAPS = 32'h6A542910;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic scl, m_sda, sda_oe, alert_oe, flag, bcast, busy;
    logic [1:0] sel_hi = HSA_SEL_LOW;
    logic [1:0] sel_lo = HSA_SEL_LOW;
    logic mass_en = 1'b0;
    logic page_en = 1'b0;
    logic conv_en = 1'b0;
    logic conv_done = 1'b0;
    logic flag_wr = 1'b0;
    logic flag_wdata = 1'b0;
    logic [HSA_NUM_ALERT-1:0] alert_bits = '0;
    logic [HSA_NUM_ALERT-1:0] alert_en = '0;
    hsa_req_s req;
    logic [7:0] rdata;
    logic [16:0] wq[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n_rd = 0;
    wire logic sda_wire = m_sda & ~sda_oe;

    function automatic logic [7:0] rd_val(input logic [7:0] a, input logic l);
        return a ^ (l ? 8'h3C : 8'hA5);
    endfunction

    assign rdata = rd_val(req.addr, req.lsb);
    always #5 i_clk = ~i_clk;

    hsa_bus_master hsa_bus_master_i (.i_sda_wire(sda_wire), .o_scl(scl), .o_sda(m_sda));
    hsa_slave hsa_slave_i (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_serial_data_input(sda_wire),
        .o_serial_data_output_oe(sda_oe), .o_alert_n_oe(alert_oe), .i_addr_select_high(sel_hi),
        .i_addr_select_low(sel_lo), .i_mass_write_en(mass_en), .i_page_en(page_en),
        .i_conv_done_alert_en(conv_en), .i_conv_done(conv_done), .i_alert_bits(alert_bits),
        .i_alert_en(alert_en), .i_flag_wr(flag_wr), .i_flag_wdata(flag_wdata), .o_req(req),
        .i_rdata(rdata), .o_alert_pending_flag(flag), .o_broadcast_mode(bcast), .o_busy(busy));

    always @(posedge i_clk) begin
        if (req.wr === 1'b1) begin
            wq.push_back({req.addr, req.lsb, req.data});
        end
        if (req.rd === 1'b1) begin
            n_rd++;
        end
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic [7:0] rx;
        logic a;
        hsa_bus_master_i.byte_io(b, 1'b1, rx, a);
        chk("ack", 17'(exp_ack), 17'(a));
    endtask

    task automatic rd(input logic [7:0] drive, input logic last, input logic [7:0] exp);
        logic [7:0] rx;
        logic a;
        hsa_bus_master_i.byte_io(drive, last, rx, a);
        chk("read byte", 17'(exp), 17'(rx));
    endtask

    task automatic wq_chk(input logic [16:0] exp);
        if (wq.size() == 0) chk("write request", exp, 'x);
        else chk("write request", exp, wq.pop_front());
    endtask

    task automatic flag_chk(input logic e);
        repeat (4) @(negedge i_clk);
        chk("alert pending", 17'(e), 17'(flag));
        chk("alert pin", 17'(e), 17'(alert_oe));
    endtask

    task automatic rd_open(input logic [7:0] cmd);
        hsa_bus_master_i.start();
        send(8'h20, 1'b0);
        send(cmd, 1'b0);
        hsa_bus_master_i.start();
        send(8'h21, 1'b0);
    endtask

    initial begin
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        flag_chk(1'b0);
        for (int k = 0; k < 8; k++) begin
            @(negedge i_clk);
            sel_hi = STRAPS[4*k+2 +: 2];
            sel_lo = STRAPS[4*k +: 2];
            repeat (8) @(negedge i_clk);
            hsa_bus_master_i.start();
            send({HSA_ADDR_BASE + 7'(k), 1'b0}, 1'b0);
            hsa_bus_master_i.stop();
            hsa_bus_master_i.start();
            send({HSA_ADDR_BASE + 7'((k + 1) % 8), 1'b0}, 1'b1);
            hsa_bus_master_i.stop();
        end
        @(negedge i_clk);
        sel_hi = HSA_SEL_HIGH;
        sel_lo = HSA_SEL_LOW;
        repeat (8) @(negedge i_clk);
        chk("broadcast mode", 17'h00001, 17'(bcast));
        hsa_bus_master_i.start();
        send(8'h20, 1'b1);
        hsa_bus_master_i.stop();
        @(negedge i_clk);
        sel_hi = HSA_SEL_LOW;
        repeat (8) @(negedge i_clk);
        chk("broadcast mode", 17'h00000, 17'(bcast));
        chk("busy", 17'h00000, 17'(busy));
        hsa_bus_master_i.start();
        send(8'h20, 1'b0);
        chk("busy", 17'h00001, 17'(busy));
        send(HSA_RAM_FIRST, 1'b0);
        send(8'hAB, 1'b0);
        send(8'hCD, 1'b0);
        send(8'hEF, 1'b1);
        hsa_bus_master_i.stop();
        wq_chk({HSA_RAM_FIRST, 1'b0, 8'hAB});
        wq_chk({HSA_RAM_FIRST, 1'b1, 8'hCD});
        chk("extra write", 17'h00000, 17'(wq.size()));
        rd_open(8'h20);
        for (int i = 0; i < 3; i++) begin
            rd(8'hFF, 1'(i == 2), (i < 2) ? rd_val(8'h20 + 8'(i), 1'b0) : HSA_BYTE_FILL);
        end
        hsa_bus_master_i.stop();
        @(negedge i_clk);
        page_en = 1'b1;
        hsa_bus_master_i.start();
        send(8'h20, 1'b0);
        send(8'h0A, 1'b0);
        for (int i = 0; i < 3; i++) begin
            send(8'h11 * 8'(i + 1), 1'b0);
        end
        hsa_bus_master_i.stop();
        for (int i = 0; i < 3; i++) begin
            wq_chk({8'h0A + 8'(i), 1'b0, 8'h11 * 8'(i + 1)});
        end
        rd_open(8'h78);
        for (int i = 0; i < 4; i++) begin
            rd(8'hFF, 1'(i == 3), rd_val(8'h78 + 8'(i / 2), 1'(i % 2)));
        end
        hsa_bus_master_i.stop();
        @(negedge i_clk);
        mass_en = 1'b1;
        hsa_bus_master_i.start();
        send(8'h3E, 1'b0);
        send(8'h05, 1'b0);
        send(8'h77, 1'b0);
        hsa_bus_master_i.stop();
        wq_chk({8'h05, 1'b0, 8'h77});
        @(negedge i_clk);
        mass_en = 1'b0;
        hsa_bus_master_i.start();
        send(8'h3E, 1'b1);
        hsa_bus_master_i.stop();
        @(negedge i_clk);
        alert_bits[9] = 1'b1;
        flag_chk(1'b0);
        alert_en[5] = 1'b1;
        alert_bits[5] = 1'b1;
        flag_chk(1'b1);
        hsa_bus_master_i.start();
        send(8'h19, 1'b0);
        rd(8'hDF, 1'b1, 8'h1F);
        hsa_bus_master_i.stop();
        flag_chk(1'b1);
        hsa_bus_master_i.start();
        send(8'h19, 1'b0);
        rd(8'hFF, 1'b1, {HSA_ADDR_BASE, 1'b0});
        hsa_bus_master_i.stop();
        flag_chk(1'b0);
        hsa_bus_master_i.start();
        send(8'h19, 1'b1);
        hsa_bus_master_i.stop();
        @(negedge i_clk);
        alert_bits[5] = 1'b0;
        @(negedge i_clk);
        alert_bits[5] = 1'b1;
        flag_chk(1'b1);
        flag_wr = 1'b1;
        flag_wdata = 1'b0;
        @(negedge i_clk);
        flag_wr = 1'b0;
        flag_chk(1'b0);
        conv_en = 1'b1;
        conv_done = 1'b1;
        @(negedge i_clk);
        conv_done = 1'b0;
        flag_chk(1'b1);
        flag_wr = 1'b1;
        @(negedge i_clk);
        flag_wr = 1'b0;
        flag_chk(1'b0);
        flag_wr = 1'b1;
        flag_wdata = 1'b1;
        @(negedge i_clk);
        flag_wr = 1'b0;
        flag_chk(1'b1);
        chk("read requests", 17'd7, 17'(n_rd));
        summarize();
    end
endmodule  // test_i2c_slave_alert_interface
`default_nettype wire
